// *** hw/interrupt_and_event_transfer.sv ***
// Purpose: Priority interrupt arbiter with per-node event transfers
// Assumes: CPU acts on o_int_request and on each o_xfer_valid cycle
// Notes: All inputs synchronous to i_clock

`timescale 1ns/1ps
`default_nettype none

module interrupt_and_event_transfer
  import irq_event_pkg::*;
#(
  parameter int NODES = NODE_COUNT,
  parameter int CHANNELS = CHANNEL_COUNT,
  parameter int FAST = FAST_COUNT,
  parameter int PW = PTR_WIDTH,
  parameter int CNTW = COUNT_WIDTH
) (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic [NODES-1:0] i_hw_event,
  input wire logic [NODES-1:0] i_sw_set,
  input wire logic [NODES-1:0] i_node_enable,
  input wire logic [NODES-1:0][LEVEL_WIDTH-1:0] i_node_priority_level,
  input wire logic [NODES-1:0] i_node_transfer,
  input wire logic [NODES-1:0][$clog2(CHANNELS)-1:0] i_node_channel,
  input wire logic [FAST-1:0] i_fast_pin,
  input wire logic [FAST-1:0][1:0] i_fast_edge,
  input wire logic [LEVEL_WIDTH-1:0] i_cpu_level,
  input wire logic i_int_accept,
  input wire logic i_trap_valid,
  input wire logic [VECTOR_WIDTH-1:0] i_trap_number,
  input wire logic i_chan_load,
  input wire logic [$clog2(CHANNELS)-1:0] i_chan_index,
  input wire logic [PW-1:0] i_chan_src,
  input wire logic [PW-1:0] i_chan_dst,
  input wire logic [CNTW-1:0] i_chan_count,
  input wire logic [MODE_WIDTH-1:0] i_chan_mode,
  output logic o_int_request,
  output logic o_int_is_trap,
  output logic [LEVEL_WIDTH-1:0] o_int_level,
  output logic [VECTOR_WIDTH-1:0] o_int_vector,
  output logic o_xfer_valid,
  output logic [PW-1:0] o_xfer_src,
  output logic [PW-1:0] o_xfer_dst,
  output logic o_xfer_word,
  output logic [$clog2(CHANNELS)-1:0] o_xfer_channel,
  output logic [NODES-1:0] o_node_request_flag,
  output logic [CHANNELS-1:0][CNTW-1:0] o_chan_count
);

  localparam int NW = $clog2(NODES);
  localparam int CW = $clog2(CHANNELS);

  // ****************************************************************
  // Parameter checks
  // ****************************************************************
  if (NODES < 2 || CHANNELS < 2 || CHANNELS != 2 ** CW || FAST > NODES
      || PW < 2 || NODES + 16 > 2 ** VECTOR_WIDTH) begin : g_bad_params
    $error("interrupt_and_event_transfer: unsupported parameters");
  end

  typedef struct packed {
    ctl_state_e state;
    logic [NODES-1:0] flags;
    logic [FAST-1:0] fast_prev;
    logic trap_pend;
    logic [VECTOR_WIDTH-1:0] trap_num;
    logic held_trap;
    logic [NW-1:0] held;
    logic int_request;
    logic [LEVEL_WIDTH-1:0] int_level;
    logic [VECTOR_WIDTH-1:0] int_vector;
    logic xfer_valid;
    logic [PW-1:0] xfer_src;
    logic [PW-1:0] xfer_dst;
    logic xfer_word;
    logic [CW-1:0] xfer_channel;
    logic [CHANNELS-1:0][PW-1:0] src;
    logic [CHANNELS-1:0][PW-1:0] dst;
    logic [CHANNELS-1:0][CNTW-1:0] count;
    logic [CHANNELS-1:0][MODE_WIDTH-1:0] mode;
  } state_s;

  state_s s;
  state_s next_s;
  logic [NODES-1:0] set_flags;
  logic [NODES-1:0] clr_flags;
  logic win_valid;
  logic [NW-1:0] win;
  logic [LEVEL_WIDTH-1:0] win_level;
  logic [CW-1:0] win_chan;
  logic win_xfer_ok;

  // Pointer step: one for bytes, two for words
  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p,
                                         input logic en,
                                         input logic word);
    return en ? p + {{(PW-2){1'b0}}, word, ~word} : p;
  endfunction

  function automatic logic [VECTOR_WIDTH-1:0] node_vector(
      input logic [NW-1:0] n);
    return NODE_TRAP_BASE + VECTOR_WIDTH'(n);
  endfunction

  // ****************************************************************
  // Request sources
  // ****************************************************************
  always_comb begin
    set_flags = i_hw_event | i_sw_set;
    for (int f = 0; f < FAST; f++) begin
      case (i_fast_edge[f])
        EDGE_RISE: set_flags[f] |= i_fast_pin[f] & ~s.fast_prev[f];
        EDGE_FALL: set_flags[f] |= ~i_fast_pin[f] & s.fast_prev[f];
        EDGE_BOTH: set_flags[f] |= i_fast_pin[f] ^ s.fast_prev[f];
        default: set_flags[f] = set_flags[f];
      endcase
    end
  end

  // ****************************************************************
  // Arbitration
  // ****************************************************************
  // Ties go to the lowest node index; level 0 can never win
  always_comb begin
    win_valid = 1'b0;
    win = '0;
    win_level = '0;
    for (int n = 0; n < NODES; n++) begin
      if (s.flags[n] && i_node_enable[n]
          && i_node_priority_level[n] > win_level) begin
        win = NW'(n);
        win_level = i_node_priority_level[n];
      end
    end
    win_valid = win_level > i_cpu_level;
    win_chan = i_node_channel[win];
    // Zero count turns the transfer into a normal interrupt unless the channel is continuous
    win_xfer_ok = i_node_transfer[win]
        && (s.count[win_chan] != '0
            || s.mode[win_chan][MODE_CONTINUOUS]);
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_s = s;
    clr_flags = '0;
    next_s.fast_prev = i_fast_pin[FAST-1:0];
    next_s.xfer_valid = 1'b0;
    if (i_trap_valid) begin
      next_s.trap_pend = 1'b1;
      next_s.trap_num = i_trap_number;
    end
    case (s.state)
      ST_IDLE: begin
        if (s.trap_pend) begin
          next_s.state = ST_OFFER;
          next_s.held_trap = 1'b1;
          next_s.int_request = 1'b1;
          next_s.int_level = i_cpu_level;
          next_s.int_vector = s.trap_num;
        end else if (win_valid && win_xfer_ok) begin
          // One stolen cycle, no vector and no state change
          clr_flags[win] = 1'b1;
          next_s.xfer_valid = 1'b1;
          next_s.xfer_src = s.src[win_chan];
          next_s.xfer_dst = s.dst[win_chan];
          next_s.xfer_word = s.mode[win_chan][MODE_WORD];
          next_s.xfer_channel = win_chan;
          next_s.src[win_chan] = bump(s.src[win_chan],
              s.mode[win_chan][MODE_INC_SRC],
              s.mode[win_chan][MODE_WORD]);
          next_s.dst[win_chan] = bump(s.dst[win_chan],
              s.mode[win_chan][MODE_INC_DST],
              s.mode[win_chan][MODE_WORD]);
          if (!s.mode[win_chan][MODE_CONTINUOUS]) begin
            next_s.count[win_chan] = s.count[win_chan] - CNTW'(1);
          end
        end else if (win_valid) begin
          next_s.state = ST_OFFER;
          next_s.held_trap = 1'b0;
          next_s.held = win;
          next_s.int_request = 1'b1;
          next_s.int_level = win_level;
          next_s.int_vector = node_vector(win);
        end
      end
      ST_OFFER: begin
        if (i_int_accept) begin
          next_s.state = ST_IDLE;
          next_s.int_request = 1'b0;
          if (s.held_trap) begin
            next_s.trap_pend = i_trap_valid;
          end else begin
            clr_flags[s.held] = 1'b1;
          end
        end else if (!s.held_trap && win_valid && win != s.held
                     && win_level > s.int_level) begin
          // A strictly higher request replaces the one on offer
          next_s.held = win;
          next_s.int_level = win_level;
          next_s.int_vector = node_vector(win);
        end else if (!s.held_trap && s.int_level <= i_cpu_level) begin
          // CPU level rose; withdraw, flag stays pending
          next_s.state = ST_IDLE;
          next_s.int_request = 1'b0;
        end
      end
      default: begin
        next_s.state = ST_IDLE;
        next_s.int_request = 1'b0;
      end
    endcase
    // A load from software overrides the channel's own update
    if (i_chan_load) begin
      next_s.src[i_chan_index] = i_chan_src;
      next_s.dst[i_chan_index] = i_chan_dst;
      next_s.count[i_chan_index] = i_chan_count;
      next_s.mode[i_chan_index] = i_chan_mode;
    end
    // Set wins over clear so no event is lost
    next_s.flags = (s.flags & ~clr_flags) | set_flags;
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      s <= '0;
      s.state <= ST_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign o_int_request = s.int_request;
  assign o_int_is_trap = s.held_trap & s.int_request;
  assign o_int_level = s.int_level;
  assign o_int_vector = s.int_vector;
  assign o_xfer_valid = s.xfer_valid;
  assign o_xfer_src = s.xfer_src;
  assign o_xfer_dst = s.xfer_dst;
  assign o_xfer_word = s.xfer_word;
  assign o_xfer_channel = s.xfer_channel;
  assign o_node_request_flag = s.flags;
  assign o_chan_count = s.count;

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_response_time: assert property (
    @(posedge i_clock) disable iff (i_reset)
    (s.state == ST_IDLE && win_valid && !s.trap_pend)
      |-> ##1 (o_int_request || o_xfer_valid))
    else $error("pending request not forwarded in time");

  chk_xfer_no_branch: assert property (
    @(posedge i_clock) disable iff (i_reset)
    o_xfer_valid |-> (s.state == ST_IDLE && !o_int_request))
    else $error("transfer overlapped an interrupt offer");

  chk_count_decrement: assert property (
    @(posedge i_clock) disable iff (i_reset)
    (o_xfer_valid && !$past(i_chan_load)
     && !s.mode[o_xfer_channel][MODE_CONTINUOUS])
      |-> s.count[o_xfer_channel]
          == CNTW'($past(s.count[win_chan]) - 1'b1))
    else $error("transfer count not decremented by one");

  chk_count_hold: assert property (
    @(posedge i_clock) disable iff (i_reset)
    (o_xfer_valid && !$past(i_chan_load)
     && s.mode[o_xfer_channel][MODE_CONTINUOUS])
      |-> s.count[o_xfer_channel] == $past(s.count[win_chan]))
    else $error("continuous mode changed the count");

  chk_pointer_step: assert property (
    @(posedge i_clock) disable iff (i_reset)
    (o_xfer_valid && !$past(i_chan_load)
     && s.mode[o_xfer_channel][MODE_INC_SRC])
      |-> s.src[o_xfer_channel] == PW'(o_xfer_src
          + (o_xfer_word ? 2 : 1)))
    else $error("source pointer step wrong");

  chk_zero_interrupt: assert property (
    @(posedge i_clock) disable iff (i_reset)
    (s.state == ST_IDLE && !s.trap_pend && win_valid
     && i_node_transfer[win] && !win_xfer_ok)
      |=> (o_int_request && !o_xfer_valid
           && o_int_vector == node_vector($past(win))))
    else $error("zero count did not vector to the node");

  chk_strict_level: assert property (
    @(posedge i_clock) disable iff (i_reset)
    ($rose(o_int_request) && !o_int_is_trap)
      |-> o_int_level > $past(i_cpu_level))
    else $error("request offered at or below CPU level");

  chk_accept_clears: assert property (
    @(posedge i_clock) disable iff (i_reset)
    (s.state == ST_OFFER && i_int_accept && !s.held_trap
     && !set_flags[s.held])
      |=> (!o_node_request_flag[$past(s.held)] && !o_int_request))
    else $error("accepted request flag not cleared");

  chk_set_wins: assert property (
    @(posedge i_clock) disable iff (i_reset)
    (i_sw_set != '0)
      |=> ((o_node_request_flag & $past(i_sw_set)) == $past(i_sw_set)))
    else $error("software request lost");

  chk_fast_rise: assert property (
    @(posedge i_clock) disable iff (i_reset)
    (i_fast_edge[0] == EDGE_RISE && $rose(i_fast_pin[0]))
      |=> o_node_request_flag[0])
    else $error("rising edge not captured");

  chk_trap_vector: assert property (
    @(posedge i_clock) disable iff (i_reset)
    (s.state == ST_IDLE && s.trap_pend)
      |=> (o_int_is_trap && o_int_vector == $past(s.trap_num)))
    else $error("trap not offered with its number");

endmodule

`default_nettype wire

// *** hw/irq_event_pkg.sv ***
// Purpose: Shared constants and types of the interrupt and event block
// Assumes: One 20 MHz core clock, synchronous active-high reset
// Notes: Sizes here are defaults; the top module may override all but LEVEL_WIDTH and VECTOR_WIDTH

package irq_event_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int NODE_COUNT = 16;
  localparam int CHANNEL_COUNT = 8;
  localparam int FAST_COUNT = 4;
  localparam int LEVEL_WIDTH = 4;
  localparam int PTR_WIDTH = 16;
  localparam int COUNT_WIDTH = 8;
  localparam int VECTOR_WIDTH = 7;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLOCK_PERIOD_NS = 50;
  localparam int RESPONSE_CYCLES = 8;

  // ****************************************************************
  // Encodings and field positions
  // ****************************************************************
  localparam logic [6:0] NODE_TRAP_BASE = 7'h10;
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam int MODE_WIDTH = 4;
  localparam int MODE_INC_SRC = 0;
  localparam int MODE_INC_DST = 1;
  localparam int MODE_WORD = 2;
  localparam int MODE_CONTINUOUS = 3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_OFFER = 2'b10
  } ctl_state_e;

endpackage

// *** tb/cpu_model.sv ***
// Purpose: Behavioural CPU that takes interrupts the block offers
// Assumes: Accept pulse is sampled by the block on the next rising edge
// Notes: i_hold keeps the CPU busy so offers stand and may be replaced

`timescale 1ns/1ps
`default_nettype none

module cpu_model (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_request,
  input wire logic i_hold,
  output logic o_accept,
  output logic [7:0] o_accept_cnt
);
  // ****************************************************************
  // Acceptance
  // ****************************************************************
  initial begin
    o_accept = 1'b0;
    o_accept_cnt = 8'h00;
  end

  always @(posedge i_clock) begin
    #1;
    if (i_reset) begin
      o_accept = 1'b0;
      o_accept_cnt = 8'h00;
    end else if (o_accept) begin
      // One-cycle pulse, so a fresh offer is never taken twice
      o_accept = 1'b0;
      o_accept_cnt = o_accept_cnt + 8'h01;
    end else begin
      o_accept = i_request && !i_hold;
    end
  end
endmodule

`default_nettype wire

// *** tb/interrupt_and_event_transfer_test.sv ***
// Purpose: Self-checking bench of the interrupt and transfer block
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Fast pins drive nodes 0..3; vectors are 0x10 plus node

`timescale 1ns/1ps
`default_nettype none

module interrupt_and_event_transfer_test
  import irq_event_pkg::*;
;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic i_clock, i_reset, i_int_accept, i_trap_valid, i_chan_load, hold;
  logic [15:0] i_hw_event, i_sw_set, i_node_enable, i_node_transfer;
  logic [15:0][3:0] i_node_priority_level;
  logic [15:0][2:0] i_node_channel;
  logic [3:0] i_fast_pin, i_cpu_level, i_chan_mode, o_int_level;
  logic [3:0][1:0] i_fast_edge;
  logic [6:0] i_trap_number, o_int_vector;
  logic [2:0] i_chan_index, o_xfer_channel;
  logic [15:0] i_chan_src, i_chan_dst, o_xfer_src, o_xfer_dst;
  logic [15:0] o_node_request_flag;
  logic [7:0] i_chan_count, accept_cnt;
  logic [7:0][7:0] o_chan_count;
  logic o_int_request, o_int_is_trap, o_xfer_valid, o_xfer_word;
  int error_cnt = 0;
  int cmp_count = 0;

  interrupt_and_event_transfer dut (.i_clock, .i_reset, .i_hw_event,
    .i_sw_set, .i_node_enable, .i_node_priority_level, .i_node_transfer,
    .i_node_channel, .i_fast_pin, .i_fast_edge, .i_cpu_level,
    .i_int_accept, .i_trap_valid, .i_trap_number, .i_chan_load,
    .i_chan_index, .i_chan_src, .i_chan_dst, .i_chan_count, .i_chan_mode,
    .o_int_request, .o_int_is_trap, .o_int_level, .o_int_vector,
    .o_xfer_valid, .o_xfer_src, .o_xfer_dst, .o_xfer_word, .o_xfer_channel,
    .o_node_request_flag, .o_chan_count);

  cpu_model cpu (.i_clock(i_clock), .i_reset(i_reset),
    .i_request(o_int_request), .i_hold(hold), .o_accept(i_int_accept),
    .o_accept_cnt(accept_cnt));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic tick();
    @(posedge i_clock);
    #1;
  endtask

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic fire(input int n);
    i_hw_event[n] = 1'b1;
    tick();
    i_hw_event[n] = 1'b0;
  endtask

  task automatic take_offer(input logic [6:0] vec, input logic [3:0] lvl,
                            input logic trap);
    int i;
    logic [7:0] c;
    for (i = 0; i < RESPONSE_CYCLES && o_int_request !== 1'b1; i++) tick();
    c = accept_cnt;
    check("offer", o_int_request, 1'b1);
    check("vector", o_int_vector, vec);
    check("level", o_int_level, lvl);
    check("is_trap", o_int_is_trap, trap);
    for (i = 0; i < 4 && accept_cnt === c; i++) tick();
    if (!trap) check("flag", o_node_request_flag[vec[3:0]], 1'b0);
  endtask

  task automatic load(input logic [2:0] ch, input logic [15:0] s, d,
                      input logic [7:0] n, input logic [3:0] m);
    i_chan_index = ch;
    i_chan_src = s;
    i_chan_dst = d;
    i_chan_count = n;
    i_chan_mode = m;
    i_chan_load = 1'b1;
    tick();
    i_chan_load = 1'b0;
    check("load", o_chan_count[ch], n);
  endtask

  task automatic xfer(input int n, input logic [15:0] s, d,
                      input logic w, input logic [2:0] ch,
                      input logic [7:0] cnt);
    fire(n);
    tick();
    check("xfer_valid", o_xfer_valid, 1'b1);
    check("xfer_src", o_xfer_src, s);
    check("xfer_dst", o_xfer_dst, d);
    check("xfer_word", o_xfer_word, w);
    check("xfer_channel", o_xfer_channel, ch);
    check("chan_count", o_chan_count[ch], cnt);
    check("no_branch", o_int_request, 1'b0);
    tick();
    check("one_cycle", o_xfer_valid, 1'b0);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic test_priority();
    i_node_priority_level[2] = 4'h3;
    i_node_priority_level[6] = 4'h9;
    i_cpu_level = 4'hA;
    i_hw_event = 16'h0044;
    tick();
    i_hw_event = 16'h0000;
    repeat (3) tick();
    check("refused", o_int_request, 1'b0);
    check("pending", o_node_request_flag[6], 1'b1);
    i_cpu_level = 4'h0;
    take_offer(7'h16, 4'h9, 1'b0);
    take_offer(7'h12, 4'h3, 1'b0);
  endtask

  task automatic test_preempt();
    hold = 1'b1;
    i_node_priority_level[4] = 4'h4;
    i_node_priority_level[5] = 4'h4;
    i_node_priority_level[7] = 4'h8;
    fire(4);
    tick();
    check("first", o_int_vector, 7'h14);
    fire(5);
    repeat (2) tick();
    check("equal_kept", o_int_vector, 7'h14);
    fire(7);
    repeat (2) tick();
    check("higher_wins", o_int_vector, 7'h17);
    i_cpu_level = 4'h8;
    repeat (2) tick();
    check("withdrawn", o_int_request, 1'b0);
    i_cpu_level = 4'h0;
    hold = 1'b0;
    take_offer(7'h17, 4'h8, 1'b0);
    take_offer(7'h14, 4'h4, 1'b0);
    take_offer(7'h15, 4'h4, 1'b0);
  endtask

  task automatic test_soft();
    i_node_priority_level[12] = 4'h7;
    i_sw_set[12] = 1'b1;
    tick();
    i_sw_set[12] = 1'b0;
    take_offer(7'h1C, 4'h7, 1'b0);
    i_trap_number = 7'h2A;
    i_trap_valid = 1'b1;
    tick();
    i_trap_valid = 1'b0;
    take_offer(7'h2A, 4'h0, 1'b1);
  endtask

  task automatic test_transfer();
    load(3'h1, 16'h1000, 16'h2000, 8'h02, 4'h7);
    i_node_transfer[10:9] = 2'h3;
    i_node_channel[9] = 3'h1;
    i_node_channel[10] = 3'h7;
    i_node_priority_level[10:9] = {4'h6, 4'h6};
    xfer(9, 16'h1000, 16'h2000, 1'b1, 3'h1, 8'h01);
    xfer(9, 16'h1002, 16'h2002, 1'b1, 3'h1, 8'h00);
    fire(9);
    take_offer(7'h19, 4'h6, 1'b0);
    // Continuous byte channel: count must stay put
    load(3'h7, 16'h4000, 16'h3000, 8'h05, 4'hA);
    xfer(10, 16'h4000, 16'h3000, 1'b0, 3'h7, 8'h05);
    xfer(10, 16'h4000, 16'h3001, 1'b0, 3'h7, 8'h05);
  endtask

  task automatic test_fast();
    int f;
    int exp_n;
    logic [7:0] c;
    for (f = 0; f < 4; f++) begin
      // Node 0 rising, 1 falling, 2 both, 3 none
      i_fast_edge[f] = f[1:0] + 2'h1;
      exp_n = (f == 3) ? 0 : (f == 2) ? 2 : 1;
      i_node_priority_level[f] = 4'h2;
      c = accept_cnt;
      i_fast_pin[f] = 1'b1;
      repeat (6) tick();
      i_fast_pin[f] = 1'b0;
      repeat (6) tick();
      check("edges", accept_cnt - c, exp_n);
    end
  endtask

  // ****************************************************************
  // Clock, main sequence and watchdog
  // ****************************************************************
  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end

  initial begin
    i_reset = 1'b1;
    {i_hw_event, i_sw_set, i_node_transfer} = '0;
    i_node_enable = 16'hFFFF;
    i_node_priority_level = {16{4'h1}};
    {i_node_channel, i_fast_pin, i_fast_edge, i_cpu_level} = '0;
    {i_trap_valid, i_trap_number, i_chan_load, i_chan_index} = '0;
    {i_chan_src, i_chan_dst, i_chan_count, i_chan_mode, hold} = '0;
    repeat (10) @(posedge i_clock);
    #1;
    i_reset = 1'b0;
    check("reset_offer", o_int_request, 1'b0);
    check("reset_flags", o_node_request_flag, 16'h0000);
    test_priority();
    test_preempt();
    test_soft();
    test_transfer();
    test_fast();
    end_of_test();
  end

  initial begin
    // Whole run needs well under 400 cycles
    repeat (3000) @(posedge i_clock);
    error_cnt++;
    end_of_test();
  end
endmodule

`default_nettype wire
